// >>> cpc_cell_src.sv
// Far-side cell source: hands the five header bytes of one cell to the block.
// Assumes one mclk domain; start is a one-cycle pulse from the bench.
`timescale 1ns/1ns
module cpc_cell_src
(
    input  wire logic  mclk,
    input  wire logic  rst_b,
    input  wire logic  start,
    output logic [5:0] hdr_index,
    output logic [7:0] hdr_byte_in
);
    logic [3:0] cnt_reg;
    logic       busy_reg;
    logic [3:0] cnt_next;
    assign cnt_next = cnt_reg + 4'h1;
    // Each byte stands two cycles; between cells the lane churns so stale data cannot pass
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_reg     <= 4'h0;
            busy_reg    <= 1'b0;
            hdr_index   <= 6'h3f;
            hdr_byte_in <= 8'h00;
        end
        else if (start || (busy_reg && cnt_reg != 4'h9))
        begin
            cnt_reg     <= start ? 4'h0 : cnt_next;
            busy_reg    <= 1'b1;
            hdr_index   <= start ? 6'h00 : {3'h0, cnt_next[3:1]};
            hdr_byte_in <= 8'hff;
        end
        else
        begin
            busy_reg    <= 1'b0;
            hdr_index   <= 6'h3f;
            hdr_byte_in <= ~hdr_byte_in;
        end
    end
endmodule : cpc_cell_src

// >>> cpc_pkg.sv
// Package for the cell port configuration register bank.
// Assumes a 16-bit register port addressed by word index.
package cpc_pkg;
    localparam logic [7:0]  ADDR_CAS0_LO      = 8'h29;
    localparam logic [7:0]  ADDR_CAS0_HI      = 8'h2a;
    localparam logic [7:0]  ADDR_CAS_IDLE     = 8'h2b;
    localparam logic [7:0]  ADDR_THR01        = 8'h2c;
    localparam logic [7:0]  ADDR_THR23        = 8'h2d;
    localparam logic [7:0]  ADDR_BUS_CFG      = 8'h28;
    localparam logic [15:0] RST_CAS0          = 16'hbbbb;
    localparam logic [15:0] RST_CAS_IDLE      = 16'h000d;
    localparam logic [15:0] RST_THR           = 16'h0fff;
    localparam logic [15:0] RST_BUS_CFG       = 16'h0000;
    localparam int          POS_MAP           = 0;
    localparam int          POS_MASTER        = 3;
    localparam int          POS_LEVEL         = 4;
    localparam int          POS_BASE          = 5;
    localparam int          POS_PRTY          = 10;
    localparam int          POS_RANGE         = 11;
    localparam logic [3:0]  CAS_IDLE_MASK     = 4'hf;
    localparam logic [2:0]  MAP_OFF           = 3'h0;
    localparam logic [2:0]  MAP_UDF           = 3'h1;
    localparam logic [2:0]  MAP_VCI_LO        = 3'h2;
    localparam logic [2:0]  MAP_VCI_HI        = 3'h3;
    localparam logic [2:0]  MAP_VPI           = 3'h4;
    localparam logic [2:0]  MAP_GFC           = 3'h5;

    typedef struct packed {
        logic [2:0] port_range;
        logic       parity_en;
        logic [4:0] base_addr;
        logic       level1;
        logic       master;
        logic [2:0] map_mode;
    } cpc_cfg_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic       wr;
        logic       rd;
    } cpc_req_s;
endpackage : cpc_pkg

// >>> cpc_regs.sv
// Cell port configuration registers and the logic they steer.
// Assumes one clock, a single-cycle register port, header bytes supplied in order.
`timescale 1ns/1ns
// How it works
// RULE1: Port range used only for level 2 slave with mapping off.
// RULE2: Range 000 enables all eight, 001..111 enable ports 0..code-1.
// RULE3: Parity errors are flagged only while parity enable is set.
// RULE4: Five-bit base address sets PHY address; software keeps it zero at level 1.
// RULE5: Level bit 0 selects level 2; master bit 1 selects ATM master.
// RULE6: Source port number optionally written into header; code 000 disables.
// RULE7: Mapping code picks UDF, VCI low, VCI high, VPI or GFC field.
// RULE8: Four-bit frame-0 pattern per port; zeroed out for T1 ports.
// RULE9: Idle pattern drives unused transmit timeslots.
// RULE10: Eight-bit threshold per port, even port low byte, odd high byte.
// RULE11: Backpressure asserts when buffered count reaches the threshold.
module cpc_regs
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire cpc_pkg::cpc_req_s bus_req,
    output logic [15:0]            bus_rdata,
    input  wire logic [7:0]        t1_mode,
    input  wire logic [31:0]       cell_fill,
    output logic [3:0]             tx_bp,
    input  wire logic [4:0]        phy_addr,
    output logic                   phy_selected,
    input  wire logic [2:0]        poll_port,
    output logic                   port_enabled,
    input  wire logic              parity_err_raw,
    output logic                   parity_err,
    input  wire logic [2:0]        source_port_number,
    input  wire logic [5:0]        hdr_index,
    input  wire logic [7:0]        hdr_byte_in,
    output logic [7:0]             hdr_byte_out,
    input  wire logic              slot_unused,
    input  wire logic [3:0]        slot_sig_in,
    output logic [3:0]             slot_sig_out,
    output logic [31:0]            sig_frame0_pattern,
    output cpc_pkg::cpc_cfg_s      cfg
);
    logic [15:0] cas0_lo_reg;
    logic [15:0] cas0_hi_reg;
    logic [15:0] cas_idle_reg;
    logic [15:0] thr01_reg;
    logic [15:0] thr23_reg;
    logic [15:0] bus_cfg_reg;
    logic [15:0] rdata_next;
    logic        range_active;

    function automatic logic wr_hit(input cpc_pkg::cpc_req_s r, input logic [7:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    // Three of the header fields sit in bits 3:1 of their byte
    function automatic logic [7:0] put_mid(input logic [7:0] b, input logic [2:0] p);
        put_mid = {b[7:4], p, b[0]};
    endfunction : put_mid

    // Configuration writes
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cas0_lo_reg  <= cpc_pkg::RST_CAS0;
            cas0_hi_reg  <= cpc_pkg::RST_CAS0;
            cas_idle_reg <= cpc_pkg::RST_CAS_IDLE;
            thr01_reg    <= cpc_pkg::RST_THR;
            thr23_reg    <= cpc_pkg::RST_THR;
            bus_cfg_reg  <= cpc_pkg::RST_BUS_CFG;
        end
        else
        begin
            if (wr_hit(bus_req, cpc_pkg::ADDR_CAS0_LO))
                cas0_lo_reg <= bus_req.wdata;
            if (wr_hit(bus_req, cpc_pkg::ADDR_CAS0_HI))
                cas0_hi_reg <= bus_req.wdata;
            if (wr_hit(bus_req, cpc_pkg::ADDR_CAS_IDLE))
                cas_idle_reg <= {12'h000, bus_req.wdata[3:0]};
            if (wr_hit(bus_req, cpc_pkg::ADDR_THR01))
                thr01_reg <= bus_req.wdata; // [RULE10]
            if (wr_hit(bus_req, cpc_pkg::ADDR_THR23))
                thr23_reg <= bus_req.wdata; // [RULE10]
            if (wr_hit(bus_req, cpc_pkg::ADDR_BUS_CFG))
                bus_cfg_reg <= {1'b0, bus_req.wdata[14:0]};
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = 16'h0000;
        case (bus_req.addr)
            cpc_pkg::ADDR_CAS0_LO:  rdata_next = cas0_lo_reg;
            cpc_pkg::ADDR_CAS0_HI:  rdata_next = cas0_hi_reg;
            cpc_pkg::ADDR_CAS_IDLE: rdata_next = cas_idle_reg;
            cpc_pkg::ADDR_THR01:    rdata_next = thr01_reg;
            cpc_pkg::ADDR_THR23:    rdata_next = thr23_reg;
            cpc_pkg::ADDR_BUS_CFG:  rdata_next = bus_cfg_reg;
            default:                rdata_next = 16'h0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            bus_rdata <= 16'h0000;
        else if (bus_req.rd)
            bus_rdata <= rdata_next;
        else
            bus_rdata <= 16'h0000;
    end

    always_comb
    begin
        cfg.map_mode   = bus_cfg_reg[cpc_pkg::POS_MAP +: 3];
        cfg.master     = bus_cfg_reg[cpc_pkg::POS_MASTER]; // [RULE5]
        cfg.level1     = bus_cfg_reg[cpc_pkg::POS_LEVEL];  // [RULE5]
        cfg.base_addr  = bus_cfg_reg[cpc_pkg::POS_BASE +: 5];
        cfg.parity_en  = bus_cfg_reg[cpc_pkg::POS_PRTY];
        cfg.port_range = bus_cfg_reg[cpc_pkg::POS_RANGE +: 3];
    end

    // Range limiting only applies to a level 2 slave without header mapping
    assign range_active = !cfg.level1 && !cfg.master && (cfg.map_mode == cpc_pkg::MAP_OFF); // [RULE1]

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_enabled <= 1'b0;
            phy_selected <= 1'b0;
            parity_err   <= 1'b0;
        end
        else
        begin
            if (!range_active || cfg.port_range == 3'h0)
                port_enabled <= 1'b1; // [RULE1] [RULE2]
            else
                port_enabled <= (poll_port < cfg.port_range); // [RULE2]
            // Master drives addresses itself, so it never answers as a PHY
            phy_selected <= !cfg.master && (phy_addr == cfg.base_addr); // [RULE4] [RULE5]
            parity_err   <= parity_err_raw && cfg.parity_en; // [RULE3]
        end
    end

    // Header byte rewrite; GFC and VPI[7:4] share byte 0, VCI[7:4] ends byte 2, byte 4 is UDF
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            hdr_byte_out <= 8'h00;
        else
        begin
            hdr_byte_out <= hdr_byte_in;
            case (cfg.map_mode) // [RULE6] [RULE7]
                cpc_pkg::MAP_UDF:
                    if (hdr_index == 6'h4)
                        hdr_byte_out <= {hdr_byte_in[7:3], source_port_number};
                cpc_pkg::MAP_VCI_LO:
                    if (hdr_index == 6'h2)
                        hdr_byte_out <= put_mid(hdr_byte_in, source_port_number);
                cpc_pkg::MAP_VCI_HI:
                    if (hdr_index == 6'h1)
                        hdr_byte_out <= put_mid(hdr_byte_in, source_port_number);
                cpc_pkg::MAP_VPI:
                    if (hdr_index == 6'h0)
                        hdr_byte_out <= put_mid(hdr_byte_in, source_port_number);
                cpc_pkg::MAP_GFC:
                    if (hdr_index == 6'h0)
                        hdr_byte_out <= {source_port_number, hdr_byte_in[4:0]};
                default:
                    hdr_byte_out <= hdr_byte_in;
            endcase
        end
    end

    // Idle timeslot fill
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            slot_sig_out <= 4'h0;
        else if (slot_unused)
            slot_sig_out <= cas_idle_reg[3:0] & cpc_pkg::CAS_IDLE_MASK; // [RULE9]
        else
            slot_sig_out <= slot_sig_in;
    end

    // Frame-0 patterns per port, forced to zero for T1 lines
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_sig
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    sig_frame0_pattern[gi*4 +: 4] <= 4'h0;
                else if (t1_mode[gi])
                    sig_frame0_pattern[gi*4 +: 4] <= 4'h0; // [RULE8]
                else if (gi < 4)
                    sig_frame0_pattern[gi*4 +: 4] <= cas0_lo_reg[(gi%4)*4 +: 4]; // [RULE8]
                else
                    sig_frame0_pattern[gi*4 +: 4] <= cas0_hi_reg[(gi%4)*4 +: 4];
            end
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_bp
            logic [7:0] thr;
            assign thr = (gi < 2) ? thr01_reg[(gi%2)*8 +: 8] : thr23_reg[(gi%2)*8 +: 8]; // [RULE10]
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    tx_bp[gi] <= 1'b0;
                else
                    tx_bp[gi] <= (cell_fill[gi*8 +: 8] >= thr); // [RULE11]
            end
        end
    endgenerate

    property p_parity;
        @(posedge mclk) disable iff (!rst_b)
        !cfg.parity_en |=> !parity_err;
    endproperty
    a_parity: assert property (p_parity) else $error("parity flagged while disabled"); // [RULE3]

    property p_bp;
        @(posedge mclk) disable iff (!rst_b)
        (cell_fill[7:0] >= thr01_reg[7:0]) |=> tx_bp[0];
    endproperty
    a_bp: assert property (p_bp) else $error("port 0 backpressure missing"); // [RULE11]

    property p_bp_off;
        @(posedge mclk) disable iff (!rst_b)
        (cell_fill[15:8] < thr01_reg[15:8]) |=> !tx_bp[1];
    endproperty
    a_bp_off: assert property (p_bp_off) else $error("port 1 backpressure stuck"); // [RULE10]

    property p_range;
        @(posedge mclk) disable iff (!rst_b)
        (range_active && cfg.port_range == 3'h1 && poll_port != 3'h0 && $stable(bus_cfg_reg)) |=> !port_enabled;
    endproperty
    a_range: assert property (p_range) else $error("port above range enabled"); // [RULE2]

    property p_norange;
        @(posedge mclk) disable iff (!rst_b)
        cfg.master |=> port_enabled;
    endproperty
    a_norange: assert property (p_norange) else $error("range applied outside level 2 slave"); // [RULE1]

    property p_master_sel;
        @(posedge mclk) disable iff (!rst_b)
        cfg.master |=> !phy_selected;
    endproperty
    a_master_sel: assert property (p_master_sel) else $error("master answered as PHY"); // [RULE5]

    property p_base;
        @(posedge mclk) disable iff (!rst_b)
        (!cfg.master && phy_addr == cfg.base_addr) |=> phy_selected;
    endproperty
    a_base: assert property (p_base) else $error("base address not answered"); // [RULE4]

    property p_idle;
        @(posedge mclk) disable iff (!rst_b)
        slot_unused |=> (slot_sig_out == $past(cas_idle_reg[3:0]));
    endproperty
    a_idle: assert property (p_idle) else $error("idle pattern not sent"); // [RULE9]

    property p_t1;
        @(posedge mclk) disable iff (!rst_b)
        t1_mode[0] |=> (sig_frame0_pattern[3:0] == 4'h0);
    endproperty
    a_t1: assert property (p_t1) else $error("T1 port pattern not ignored"); // [RULE8]

    sequence s_map_off;
        cfg.map_mode == cpc_pkg::MAP_OFF;
    endsequence
    property p_map;
        @(posedge mclk) disable iff (!rst_b)
        s_map_off |=> (hdr_byte_out == $past(hdr_byte_in));
    endproperty
    a_map: assert property (p_map) else $error("header changed with mapping off"); // [RULE6]

    property p_udf;
        @(posedge mclk) disable iff (!rst_b)
        (cfg.map_mode == cpc_pkg::MAP_UDF && hdr_index == 6'd4) |=> (hdr_byte_out[2:0] == $past(source_port_number));
    endproperty
    a_udf: assert property (p_udf) else $error("UDF port number missing"); // [RULE7]

    property p_gfc;
        @(posedge mclk) disable iff (!rst_b)
        (cfg.map_mode == cpc_pkg::MAP_GFC && hdr_index == 6'h0) |=> (hdr_byte_out[7:5] == $past(source_port_number));
    endproperty
    a_gfc: assert property (p_gfc) else $error("GFC port number missing"); // [RULE7]

    property p_vpi;
        @(posedge mclk) disable iff (!rst_b)
        (cfg.map_mode == cpc_pkg::MAP_VPI && hdr_index == 6'h0) |=> (hdr_byte_out[3:1] == $past(source_port_number));
    endproperty
    a_vpi: assert property (p_vpi) else $error("VPI port number missing"); // [RULE7]

    property p_vci_hi;
        @(posedge mclk) disable iff (!rst_b)
        (cfg.map_mode == cpc_pkg::MAP_VCI_HI && hdr_index == 6'h1) |=> (hdr_byte_out[3:1] == $past(source_port_number));
    endproperty
    a_vci_hi: assert property (p_vci_hi) else $error("VCI high port number missing"); // [RULE7]

    property p_vci_lo;
        @(posedge mclk) disable iff (!rst_b)
        (cfg.map_mode == cpc_pkg::MAP_VCI_LO && hdr_index == 6'h2) |=> (hdr_byte_out[3:1] == $past(source_port_number));
    endproperty
    a_vci_lo: assert property (p_vci_lo) else $error("VCI low port number missing"); // [RULE7]

    property p_parity_on;
        @(posedge mclk) disable iff (!rst_b)
        (cfg.parity_en && parity_err_raw) |=> parity_err;
    endproperty
    a_parity_on: assert property (p_parity_on) else $error("parity error lost while enabled"); // [RULE3]

    property p_bp_release;
        @(posedge mclk) disable iff (!rst_b)
        (cell_fill[7:0] < thr01_reg[7:0]) |=> !tx_bp[0];
    endproperty
    a_bp_release: assert property (p_bp_release) else $error("port 0 backpressure not released"); // [RULE11]

    property p_bp_odd;
        @(posedge mclk) disable iff (!rst_b)
        (cell_fill[31:24] >= thr23_reg[15:8]) |=> tx_bp[3];
    endproperty
    a_bp_odd: assert property (p_bp_odd) else $error("port 3 backpressure missing"); // [RULE10]

    property p_range_all;
        @(posedge mclk) disable iff (!rst_b)
        (cfg.port_range == 3'h0) |=> port_enabled;
    endproperty
    a_range_all: assert property (p_range_all) else $error("full range left a port disabled"); // [RULE2]

    property p_level1;
        @(posedge mclk) disable iff (!rst_b)
        cfg.level1 |=> port_enabled;
    endproperty
    a_level1: assert property (p_level1) else $error("range applied at level 1"); // [RULE1]

    property p_slot_pass;
        @(posedge mclk) disable iff (!rst_b)
        !slot_unused |=> (slot_sig_out == $past(slot_sig_in));
    endproperty
    a_slot_pass: assert property (p_slot_pass) else $error("used timeslot overwritten"); // [RULE9]

    property p_e1_hi;
        @(posedge mclk) disable iff (!rst_b)
        !t1_mode[4] |=> (sig_frame0_pattern[19:16] == $past(cas0_hi_reg[3:0]));
    endproperty
    a_e1_hi: assert property (p_e1_hi) else $error("port 4 pattern not applied"); // [RULE8]
endmodule : cpc_regs

// >>> test_cell_port_config_regs.sv
// Self-checking bench for the cell port configuration registers.
// Assumes a 100 MHz mclk and the cell source model on the header lane.
`timescale 1ns/1ns
module test_cell_port_config_regs;
    logic              mclk, rst_b, port_enabled, parity_err_raw, parity_err, phy_selected, slot_unused, src_start;
    cpc_pkg::cpc_req_s bus_req;
    cpc_pkg::cpc_cfg_s cfg;
    logic [15:0]       bus_rdata;
    logic [7:0]        t1_mode, hdr_byte_in, hdr_byte_out;
    logic [31:0]       cell_fill, sig_frame0_pattern;
    logic [3:0]        tx_bp, slot_sig_in, slot_sig_out;
    logic [4:0]        phy_addr;
    logic [2:0]        poll_port, source_port_number;
    logic [5:0]        hdr_index;
    int                bad_count, comparisons;

    cpc_regs dut_u (.mclk, .rst_b, .bus_req, .bus_rdata, .t1_mode, .cell_fill, .tx_bp, .phy_addr, .phy_selected,
        .poll_port, .port_enabled, .parity_err_raw, .parity_err, .source_port_number, .hdr_index, .hdr_byte_in,
        .hdr_byte_out, .slot_unused, .slot_sig_in, .slot_sig_out, .sig_frame0_pattern, .cfg);
    cpc_cell_src src_u (.mclk, .rst_b, .start(src_start), .hdr_index, .hdr_byte_in);

    always #5 mclk = ~mclk;

    task automatic final_report();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so it is sampled there
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk(32'(bus_rdata), 32'(e));
    endtask : rd_chk

    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    function automatic logic [15:0] cfgw(input logic [2:0] rng, input logic pe, input logic [4:0] ba,
                                         input logic l1, input logic ms, input logic [2:0] mp);
        return (16'(rng) << cpc_pkg::POS_RANGE) | (16'(pe) << cpc_pkg::POS_PRTY) | (16'(ba) << cpc_pkg::POS_BASE)
             | (16'(l1) << cpc_pkg::POS_LEVEL) | (16'(ms) << cpc_pkg::POS_MASTER) | 16'(mp);
    endfunction : cfgw

    function automatic logic [7:0] exp_hdr(input int k, input logic [2:0] m, input logic [2:0] p);
        logic [7:0] b;
        b = 8'hff;
        if (m == 3'h5 && k == 0) b[7:5] = p;
        if (m == 3'h3 && k == 1) b[3:1] = p;
        if (m == 3'h4 && k == 0) b[3:1] = p;
        if (m == 3'h2 && k == 2) b[3:1] = p;
        if (m == 3'h1 && k == 4) b[2:0] = p;
        return b;
    endfunction : exp_hdr

    task automatic t_reset();
        rd_chk(8'h29, 16'hbbbb);
        rd_chk(8'h2a, 16'hbbbb);
        rd_chk(8'h2b, 16'h000d);
        rd_chk(8'h2c, 16'h0fff);
        rd_chk(8'h2d, 16'h0fff);
        wr_reg(8'h30, 16'hffff);
        rd_chk(8'h30, 16'h0000);
        chk(sig_frame0_pattern, 32'hbbbbbbbb);
    endtask : t_reset

    task automatic t_frame0_idle();
        wr_reg(8'h29, 16'h1234);
        wr_reg(8'h2a, 16'h5678);
        t1_mode <= 8'h05;
        wr_reg(8'h2b, 16'hfff6);
        slot_unused <= 1'b1;
        slot_sig_in <= 4'h9;
        settle();
        chk(sig_frame0_pattern, 32'h56781030);
        chk(32'(slot_sig_out), 32'h6);
        rd_chk(8'h2b, 16'h0006);
        @(posedge mclk);
        slot_unused <= 1'b0;
        settle();
        chk(32'(slot_sig_out), 32'h9);
    endtask : t_frame0_idle

    task automatic t_backpressure();
        wr_reg(8'h2c, 16'h0305);
        wr_reg(8'h2d, 16'h0204);
        cell_fill <= 32'h02030305;
        settle();
        chk(32'(tx_bp), 32'hb);
        @(posedge mclk);
        cell_fill <= 32'h02040204;
        settle();
        chk(32'(tx_bp), 32'hc);
    endtask : t_backpressure

    task automatic t_parity_phy();
        wr_reg(8'h28, cfgw(3'h0, 1'b0, 5'h15, 1'b0, 1'b0, 3'h0));
        parity_err_raw <= 1'b1;
        phy_addr <= 5'h15;
        settle();
        chk(32'(parity_err), 32'h0);
        chk(32'(phy_selected), 32'h1);
        chk(32'(cfg), 32'h02a0);
        wr_reg(8'h28, 16'hffff);
        phy_addr <= 5'h05;
        settle();
        chk(32'(parity_err), 32'h1);
        chk(32'(phy_selected), 32'h0);
        chk(32'(cfg), 32'h3fff);
        rd_chk(8'h28, 16'h7fff);
    endtask : t_parity_phy

    // Codes 8 and 9 rerun range 001 as master and with mapping, where the range has no effect
    task automatic t_range();
        for (int c = 0; c < 10; c++)
        begin
            wr_reg(8'h28, cfgw(c > 7 ? 3'h1 : 3'(c), 1'b0, 5'h0, c == 8, c == 8, c == 9 ? 3'h1 : 3'h0));
            for (int p = 0; p < 8; p++)
            begin
                poll_port <= 3'(p);
                settle();
                chk(32'(port_enabled), 32'(c > 7 || c == 0 || p < c));
                @(posedge mclk);
            end
        end
    endtask : t_range

    task automatic hdr_chk(input int k, input logic [2:0] m);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hdr_index !== 6'(k) && n < 20);
        #1;
        chk(32'(hdr_byte_out), 32'(exp_hdr(k, m, 3'h2)));
        if (n >= 20)
        begin
            bad_count++;
            final_report();
        end
    endtask : hdr_chk

    task automatic t_map();
        for (int m = 0; m < 6; m++)
        begin
            wr_reg(8'h28, cfgw(3'h0, 1'b0, 5'h0, 1'b0, 1'b0, 3'(m)));
            source_port_number <= 3'h2;
            src_start <= 1'b1;
            @(posedge mclk);
            src_start <= 1'b0;
            chk(32'(cfg.map_mode), 32'(m));
            for (int k = 0; k < 5; k++)
                hdr_chk(k, 3'(m));
        end
    endtask : t_map

    initial
    begin
        {mclk, rst_b, parity_err_raw, slot_unused, src_start, slot_sig_in, phy_addr, poll_port} = '0;
        {bus_req, t1_mode, cell_fill, source_port_number} = '0;
        bad_count = 0;
        comparisons = 0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_frame0_idle();
        t_backpressure();
        t_parity_phy();
        t_range();
        t_map();
        final_report();
    end
endmodule : test_cell_port_config_regs
